/* File: shared/pwm_defs.vh */
// Register map, field positions, reset values and timing counts of the quad modulator
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH
// Register byte offsets
`define OFS_IDENT        12'h000
`define OFS_ENABLE       12'h004
`define OFS_CLKSEL       12'h008
`define OFS_PERIOD       12'h00C
`define OFS_WIDTH0       12'h010
`define OFS_WIDTH1       12'h014
`define OFS_WIDTH2       12'h018
`define OFS_WIDTH3       12'h01C
`define OFS_IRQ_STATUS   12'h020
`define OFS_IRQ_MASK     12'h024
// Field positions
`define RUN_BIT          0
`define WSEL_LSB         0
`define PSEL_LSB         4
`define IRQ_PERIOD_BIT   0
// Reset values
`define RST_ENABLE       1'b0
`define RST_CLKSEL       8'h00
`define RST_PERIOD       16'h0000
`define RST_WIDTH        16'h0000
`define RST_MASK         1'b0
// Arbitrary neutral identification value
`define IDENT_VALUE      16'h5A01
// Clock selector codes
`define SRC_BASE         4'h0
`define SRC_RESERVED     4'h1
`define SRC_TC_FIRST     4'h2
`define SRC_PCLK_FIRST   4'h8
`define SRC_STB1         4'hC
`define SRC_STB2         4'hD
`define SRC_STB1_N       4'hE
`define SRC_STB2_N       4'hF
// Base clock rate and system clock rate in kHz
`define BASE_CLK_KHZ     25000
`define SYS_CLK_KHZ      250000
`define BASE_DIV_CYCLES  (`SYS_CLK_KHZ / `BASE_CLK_KHZ)
`endif

/* File: hdl/quad_pwm.v */
// Four-channel pulse width modulator with APB register access and period interrupt
`timescale 1ns/1ps
`include "pwm_defs.vh"

// Operation
// - Four channels, each true and complement output
// - Period and widths are 16-bit fields
// - Shared period, per-channel independent width
// - Counter decrements on each width tick
// - Zero holds until period tick, then reload
// - Interrupt event at each period start
// - Widths sampled only at period start
// - Run bit 0 enables, resets zero
// - Disabled: true outputs low, complements high
// - Clock select: period 7:4, width 3:0
// - Selector decode: base, timers, clocks, strobes
// - Period ends after period plus one ticks
// - Output high for width ticks from start
// - Maximum period same clocks, no full duty
// - Read-only identification register, fixed code
// - Period, width, select, enable reset zero
module quad_pwm #(
   parameter CHANNELS   = 4,
   parameter CNT_W      = 16,
   parameter BASE_DIV   = `BASE_DIV_CYCLES
) (
   // Clock and reset
   input  wire                  REF_CLK,
   input  wire                  SYS_RST,
   // APB slave
   input  wire                  PSEL,
   input  wire                  PENABLE,
   input  wire                  PWRITE,
   input  wire [11:0]           PADDR,
   input  wire [31:0]           PWDATA,
   output reg  [31:0]           PRDATA,
   output reg                   PREADY,
   output reg                   PSLVERR,
   // Candidate tick sources
   input  wire [5:0]            TIMER_TC,
   input  wire [3:0]            PROG_CLK,
   input  wire                  EXT_STROBE_ONE,
   input  wire                  EXT_STROBE_TWO,
   // Modulator outputs and interrupt
   output reg  [CHANNELS-1:0]   PWM_OUT,
   output reg  [CHANNELS-1:0]   PWM_OUT_N,
   output reg                   IRQ
);

   // Source synchroniser stages and base divider
   reg  [11:0]          sync1_q;
   reg  [11:0]          sync2_q;
   reg  [11:0]          sync3_q;
   reg  [7:0]           div_q;
   reg                  base_tick_q;
   // Software registers
   reg                  run_bit_q;
   reg  [3:0]           width_tick_select_q;
   reg  [3:0]           period_tick_select_q;
   reg  [CNT_W-1:0]     period_value_q;
   reg  [CNT_W-1:0]     width_value_q [0:CHANNELS-1];
   reg                  irq_status_q;
   reg                  irq_mask_q;
   // Modulator state
   reg  [CNT_W-1:0]     count_q;
   reg  [CNT_W-1:0]     elapsed_q;
   reg  [CNT_W-1:0]     width_live_q [0:CHANNELS-1];
   reg                  started_q;
   wire [11:0]          rise;
   wire                 width_tick;
   wire                 period_tick;
   wire                 period_start;
   wire                 apb_access;
   wire                 apb_wr;
   reg                  addr_ok;
   reg  [31:0]          rdata_d;
   wire [3:0]           reg_idx;
   integer              i;
   integer              j;
   integer              k;

   // Register indices from the address decoder; unmapped words get their own code
   localparam [3:0]     IDX_IDENT  = 4'h0;
   localparam [3:0]     IDX_ENABLE = 4'h1;
   localparam [3:0]     IDX_CLKSEL = 4'h2;
   localparam [3:0]     IDX_PERIOD = 4'h3;
   localparam [3:0]     IDX_WIDTH0 = 4'h4;
   localparam [3:0]     IDX_WIDTH1 = 4'h5;
   localparam [3:0]     IDX_WIDTH2 = 4'h6;
   localparam [3:0]     IDX_WIDTH3 = 4'h7;
   localparam [3:0]     IDX_STATUS = 4'h8;
   localparam [3:0]     IDX_MASK   = 4'h9;
   localparam [3:0]     IDX_NONE   = 4'hF;

   // Rising-edge tick of one selector code; one arm per code from 4'h0 to 4'hD so no index can run out of range
   function sel_tick;
      input [3:0]  code;
      input [11:0] edges;
      input        base;
      begin
         case (code)
            `SRC_BASE:     sel_tick = base;
            `SRC_RESERVED: sel_tick = 1'b0;      // Reserved code never ticks
            4'h2:          sel_tick = edges[0];  // Timer terminal counts
            4'h3:          sel_tick = edges[1];
            4'h4:          sel_tick = edges[2];
            4'h5:          sel_tick = edges[3];
            4'h6:          sel_tick = edges[4];
            4'h7:          sel_tick = edges[5];
            4'h8:          sel_tick = edges[6];  // Programmable clocks
            4'h9:          sel_tick = edges[7];
            4'hA:          sel_tick = edges[8];
            4'hB:          sel_tick = edges[9];
            `SRC_STB1:     sel_tick = edges[10];
            `SRC_STB2:     sel_tick = edges[11];
            default:       sel_tick = 1'b0;      // Inverted strobes come from inv_tick
         endcase
      end
   endfunction

   // Falling edge detect for the inverted strobe codes
   function inv_tick;
      input [3:0]  code;
      input [11:0] s2;
      input [11:0] s3;
      begin
         if (code == `SRC_STB1_N)
            inv_tick = ~s2[10] & s3[10];
         else if (code == `SRC_STB2_N)
            inv_tick = ~s2[11] & s3[11];
         else
            inv_tick = 1'b0;
      end
   endfunction

   // Byte address to register index, shared by the read, write and clear paths
   function [3:0] reg_index;
      input [11:0] addr;
      begin
         case (addr)
            `OFS_IDENT:      reg_index = IDX_IDENT;
            `OFS_ENABLE:     reg_index = IDX_ENABLE;
            `OFS_CLKSEL:     reg_index = IDX_CLKSEL;
            `OFS_PERIOD:     reg_index = IDX_PERIOD;
            `OFS_WIDTH0:     reg_index = IDX_WIDTH0;
            `OFS_WIDTH1:     reg_index = IDX_WIDTH1;
            `OFS_WIDTH2:     reg_index = IDX_WIDTH2;
            `OFS_WIDTH3:     reg_index = IDX_WIDTH3;
            `OFS_IRQ_STATUS: reg_index = IDX_STATUS;
            `OFS_IRQ_MASK:   reg_index = IDX_MASK;
            default:         reg_index = IDX_NONE;
         endcase
      end
   endfunction

   // Two-stage synchronisers, edge detect only on the settled stage
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         sync1_q <= 12'h000;
         sync2_q <= 12'h000;
         sync3_q <= 12'h000;
      end else begin
         sync1_q <= {EXT_STROBE_TWO, EXT_STROBE_ONE, PROG_CLK, TIMER_TC};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   assign rise = sync2_q & ~sync3_q;

   // Base clock divider gives a one-cycle enable at the base rate
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         div_q       <= 8'h00;
         base_tick_q <= 1'b0;
      end else if (div_q == BASE_DIV[7:0] - 8'h01) begin
         div_q       <= 8'h00;
         base_tick_q <= 1'b1;
      end else begin
         div_q       <= div_q + 8'h01;
         base_tick_q <= 1'b0;
      end
   end

   // Selector decode for both counters
   assign width_tick  = sel_tick(width_tick_select_q, rise, base_tick_q)
                      | inv_tick(width_tick_select_q, sync2_q, sync3_q);
   assign period_tick = sel_tick(period_tick_select_q, rise, base_tick_q)
                      | inv_tick(period_tick_select_q, sync2_q, sync3_q);

   // A period begins on a period tick once the count is spent
   assign period_start = run_bit_q & period_tick & (count_q == {CNT_W{1'b0}} | ~started_q);

   // Down counter, elapsed counter and width snapshots
   always @(posedge REF_CLK) begin
      if (SYS_RST || !run_bit_q) begin
         count_q   <= {CNT_W{1'b0}};
         elapsed_q <= {CNT_W{1'b0}};
         started_q <= 1'b0;
         for (i = 0; i < CHANNELS; i = i + 1)
            width_live_q[i] <= {CNT_W{1'b0}};
      end else if (period_start) begin
         count_q   <= period_value_q;
         elapsed_q <= {CNT_W{1'b0}};
         started_q <= 1'b1;
         for (i = 0; i < CHANNELS; i = i + 1)
            width_live_q[i] <= width_value_q[i];
      end else if (started_q && width_tick) begin
         // Period plus one width ticks: last tick consumes the zero state
         if (count_q != {CNT_W{1'b0}})
            count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
         if (elapsed_q != {CNT_W{1'b1}})
            elapsed_q <= elapsed_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Outputs: high for width ticks from the period start
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         PWM_OUT   <= {CHANNELS{1'b0}};
         PWM_OUT_N <= {CHANNELS{1'b1}};
      end else begin
         for (j = 0; j < CHANNELS; j = j + 1) begin
            // Saturating elapsed count means a maximum period cannot stay high
            if (run_bit_q && started_q && elapsed_q < width_live_q[j]) begin
               PWM_OUT[j]   <= 1'b1;
               PWM_OUT_N[j] <= 1'b0;
            end else begin
               PWM_OUT[j]   <= 1'b0;
               PWM_OUT_N[j] <= 1'b1;
            end
         end
      end
   end

   // APB decode: one wait state; writes land at the edge that samples PREADY high
   assign apb_access = PSEL & PENABLE & ~PREADY;
   assign apb_wr     = PSEL & PENABLE & PREADY & PWRITE & addr_ok;
   assign reg_idx    = reg_index(PADDR);

   // Address check and read mux
   always @* begin
      addr_ok = (reg_idx != IDX_NONE);
      rdata_d = 32'h00000000;
      case (reg_idx)
         IDX_IDENT:  rdata_d = {16'h0000, `IDENT_VALUE};
         IDX_ENABLE: rdata_d = {31'h0, run_bit_q};
         IDX_CLKSEL: rdata_d = {24'h000000, period_tick_select_q, width_tick_select_q};
         IDX_PERIOD: rdata_d = {16'h0000, period_value_q};
         IDX_WIDTH0: rdata_d = {16'h0000, width_value_q[0]};
         IDX_WIDTH1: rdata_d = {16'h0000, width_value_q[1]};
         IDX_WIDTH2: rdata_d = {16'h0000, width_value_q[2]};
         IDX_WIDTH3: rdata_d = {16'h0000, width_value_q[3]};
         IDX_STATUS: rdata_d = {31'h0, irq_status_q};
         IDX_MASK:   rdata_d = {31'h0, irq_mask_q};
         default:    rdata_d = 32'h00000000;
      endcase
   end

   // Bus answer one cycle after access phase starts
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= apb_access;
         PSLVERR <= apb_access & ~addr_ok;
         PRDATA  <= (apb_access && !PWRITE) ? rdata_d : 32'h00000000;
      end
   end

   // Register writes, taken at the completing edge
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         run_bit_q            <= `RST_ENABLE;
         {period_tick_select_q, width_tick_select_q} <= `RST_CLKSEL;
         period_value_q       <= `RST_PERIOD;
         irq_mask_q           <= `RST_MASK;
         for (k = 0; k < CHANNELS; k = k + 1)
            width_value_q[k] <= `RST_WIDTH;
      end else if (apb_wr) begin
         // Identifier and status words fall to the default arm; a status write of 1 clears the flag in the interrupt block
         case (reg_idx)
            IDX_ENABLE: run_bit_q <= PWDATA[`RUN_BIT];
            IDX_CLKSEL: begin
               width_tick_select_q  <= PWDATA[`WSEL_LSB +: 4];
               period_tick_select_q <= PWDATA[`PSEL_LSB +: 4];
            end
            IDX_PERIOD: period_value_q   <= PWDATA[CNT_W-1:0];
            IDX_WIDTH0: width_value_q[0] <= PWDATA[CNT_W-1:0];
            IDX_WIDTH1: width_value_q[1] <= PWDATA[CNT_W-1:0];
            IDX_WIDTH2: width_value_q[2] <= PWDATA[CNT_W-1:0];
            IDX_WIDTH3: width_value_q[3] <= PWDATA[CNT_W-1:0];
            IDX_MASK:   irq_mask_q       <= PWDATA[`IRQ_PERIOD_BIT];
            default:    run_bit_q        <= run_bit_q;
         endcase
      end
   end

   // Sticky period-start flag; a new event beats a same-cycle clear
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         irq_status_q <= 1'b0;
         IRQ          <= 1'b0;
      end else begin
         if (period_start)
            irq_status_q <= 1'b1;
         else if (apb_wr && reg_idx == IDX_STATUS && PWDATA[`IRQ_PERIOD_BIT])
            irq_status_q <= 1'b0;
         IRQ <= irq_status_q & irq_mask_q;
      end
   end

endmodule

/* File: test/pwm_load.sv */
// Load model on the modulator pins: measures pulse lengths and the period
`timescale 1ns/1ps
module pwm_load (
   // Clock
   input  wire logic        clk,
   // Observed true outputs
   input  wire logic [3:0]  pwm,
   // Measurements in clock cycles
   output logic      [15:0] per,
   output logic      [15:0] hi [4]
);
   logic [15:0] run [4];
   logic [15:0] since;
   logic [3:0]  prev;
   // Count high cycles per channel and rise-to-rise cycles of channel 0
   always @(posedge clk) begin
      prev  <= pwm;
      since <= (pwm[0] && !prev[0]) ? 16'h0001 : since + 16'h0001;
      if (pwm[0] && !prev[0]) per <= since;
      for (int i = 0; i < 4; i++) begin
         run[i] <= pwm[i] ? run[i] + 16'h0001 : 16'h0000;
         if (!pwm[i] && prev[i]) hi[i] <= run[i];
      end
   end
endmodule

/* File: test/quad_pwm_chk.sv */
// Port-level assertions for the quad modulator
`timescale 1ns/1ps
`include "pwm_defs.vh"
module quad_pwm_chk #(parameter CHANNELS = 4) (
   input wire logic                REF_CLK,
   input wire logic                SYS_RST,
   input wire logic                PSEL,
   input wire logic                PENABLE,
   input wire logic                PWRITE,
   input wire logic [11:0]         PADDR,
   input wire logic [31:0]         PWDATA,
   input wire logic [31:0]         PRDATA,
   input wire logic                PREADY,
   input wire logic [CHANNELS-1:0] PWM_OUT,
   input wire logic [CHANNELS-1:0] PWM_OUT_N,
   input wire logic                IRQ
);
   logic en_q;
   logic rd;
   logic wr;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // Shadow of the run bit, taken from completed writes
   always @(posedge REF_CLK)
      if (SYS_RST) en_q <= 1'b0;
      else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `OFS_ENABLE) en_q <= PWDATA[0];
   assign rd = PREADY && !PWRITE;
   assign wr = PREADY && PWRITE;
   sequence acc_open; PSEL && PENABLE && !PREADY; endsequence
   sequence one_wait; PREADY ##1 !PREADY; endsequence
   pready_wait_a: assert property (acc_open |=> one_wait)
      else $error("access not answered after one wait");
   ident_fixed_a: assert property (rd && PADDR == `OFS_IDENT |-> PRDATA == {16'h0, `IDENT_VALUE})
      else $error("identifier read wrong");
   enable_rsvd_a: assert property (rd && PADDR == `OFS_ENABLE |-> PRDATA[31:1] == 31'h0)
      else $error("enable reserved bits set");
   clksel_rsvd_a: assert property (rd && PADDR == `OFS_CLKSEL |-> PRDATA[31:8] == 24'h0)
      else $error("select reserved bits set");
   period_width_a: assert property (rd && PADDR == `OFS_PERIOD |-> PRDATA[31:16] == 16'h0)
      else $error("period wider than 16 bits");
   out_complement_a: assert property (PWM_OUT_N == ~PWM_OUT)
      else $error("outputs not complementary");
   idle_out_a: assert property (!en_q && !$past(en_q) |-> PWM_OUT == '0 && PWM_OUT_N == '1)
      else $error("outputs not idle while stopped");
   start_run_a: assert property ($rose(|PWM_OUT) |-> $past(en_q))
      else $error("pulse started while stopped");
   irq_sticky_a: assert property ($fell(IRQ) |-> $past(wr) || $past(wr, 2))
      else $error("interrupt dropped without a write");
endmodule
bind quad_pwm quad_pwm_chk #(.CHANNELS(CHANNELS)) chk_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PWM_OUT(PWM_OUT), .PWM_OUT_N(PWM_OUT_N), .IRQ(IRQ));

/* File: test/quad_pwm_dual_clock_tb_top.sv */
// Bench for the quad modulator: register rows, pulse timing, interrupt and source cases
`timescale 1ns/1ps
`include "pwm_defs.vh"
module quad_pwm_dual_clock_tb_top;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, src = 0, prdy, perr, irq, erv;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwd = 32'h0, prd, rdv;
   logic [3:0]  po, pon, cyc = 4'h0;
   logic [15:0] per, hi [4];
   int          err_total = 0, num_checks = 0;
   // Address beside the word it reads after reset; last row is unmapped
   logic [43:0] rows [11] = '{{`OFS_IDENT, 16'h0, `IDENT_VALUE}, {`OFS_ENABLE, 32'h0}, {`OFS_CLKSEL, 32'h0},
      {`OFS_PERIOD, 32'h0}, {`OFS_WIDTH0, 32'h0}, {`OFS_WIDTH1, 32'h0}, {`OFS_WIDTH2, 32'h0},
      {`OFS_WIDTH3, 32'h0}, {`OFS_IRQ_STATUS, 32'h0}, {`OFS_IRQ_MASK, 32'h0}, {12'h028, 32'h0}};
   quad_pwm dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .TIMER_TC({6{src}}), .PROG_CLK({4{src}}),
      .EXT_STROBE_ONE(src), .EXT_STROBE_TWO(src), .PWM_OUT(po), .PWM_OUT_N(pon), .IRQ(irq));
   pwm_load load (.clk(clk), .pwm(po), .per(per), .hi(hi));
   initial forever #2 clk = ~clk;
   // Shared tick source: one rise and one fall every 16 cycles
   always @(posedge clk) begin
      cyc <= cyc + 4'h1;
      src <= cyc[3];
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits for the slave; only the watchdog ends a hang
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; pwr <= w; paddr <= a; pwd <= d;
      @(posedge clk) pen <= 1;
      do @(posedge clk); while (prdy !== 1'b1);
      rdv = prd;
      erv = perr;
      psel <= 0; pen <= 0;
      @(posedge clk);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task settle(input int n);
      repeat (n) @(posedge po[0]);
      repeat (2) @(posedge clk);
   endtask
   initial begin
      #100000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      apb(1, `OFS_IDENT, 32'h0);
      foreach (rows[i]) begin
         apb(0, rows[i][43:32], 32'h0);
         chk(rdv, rows[i][31:0]);
         chk(erv, rows[i][43:32] == 12'h028);
      end
      // Base clock on both selectors, period 3, widths 1, 2, 3, 0
      apb(1, `OFS_PERIOD, 32'h3);
      for (int i = 0; i < 4; i++) apb(1, `OFS_WIDTH0 + 12'h4 * i, (i + 1) % 4);
      apb(1, `OFS_IRQ_MASK, 32'h1);
      apb(1, `OFS_ENABLE, 32'h1);
      settle(2);
      for (int i = 0; i < 3; i++) chk(hi[i], `BASE_DIV_CYCLES * (i + 1));
      chk(per, `BASE_DIV_CYCLES * 4);
      chk(po[3], 1'b0);
      chk(irq, 1'b1);
      // Mid-pulse width change must wait for the next period
      @(posedge po[0]);
      apb(1, `OFS_WIDTH0, 32'h2);
      @(negedge po[0]);
      repeat (2) @(posedge clk);
      chk(hi[0], `BASE_DIV_CYCLES);
      @(negedge po[0]);
      repeat (2) @(posedge clk);
      chk(hi[0], `BASE_DIV_CYCLES * 2);
      apb(1, `OFS_ENABLE, 32'h0);
      repeat (2) @(posedge clk);
      chk({po, pon}, 8'h0F);
      apb(1, `OFS_IRQ_STATUS, 32'h1);
      repeat (60) @(posedge clk);
      chk(irq, 1'b0);
      apb(0, `OFS_IRQ_STATUS, 32'h0);
      chk(rdv, 32'h0);
      apb(1, `OFS_IRQ_MASK, 32'h0);
      apb(1, `OFS_ENABLE, 32'h1);
      settle(1);
      chk(irq, 1'b0);
      apb(0, `OFS_IRQ_STATUS, 32'h0);
      chk(rdv, 32'h1);
      apb(1, `OFS_IRQ_MASK, 32'h1);
      @(posedge clk);
      chk(irq, 1'b1);
      // Every timer, clock and strobe selector code on both clocks; source gives a tick each 16 cycles
      for (int c = 2; c < 16; c++) begin
         apb(1, `OFS_ENABLE, 32'h0);
         apb(1, `OFS_CLKSEL, {24'hFFFFFF, c[3:0], c[3:0]});
         apb(0, `OFS_CLKSEL, 32'h0);
         chk(rdv, {24'h0, c[3:0], c[3:0]});
         apb(1, `OFS_ENABLE, 32'h1);
         settle(2);
         chk(per, 32'd64);
         chk(hi[0], 32'd32);
      end
      // Reset in mid-run: outputs idle, interrupt low, registers back to zero
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk({po, pon}, 8'h0F);
      chk(irq, 1'b0);
      apb(0, `OFS_ENABLE, 32'h0);
      chk(rdv, 32'h0);
      apb(0, `OFS_PERIOD, 32'h0);
      chk(rdv, 32'h0);
      tally_and_finish;
   end
endmodule
